// ===== hdl/sadc_regs.vh
// Purpose: constants for the converter control block
// Assumes: byte-wide registers, one per aligned 32-bit APB word
// Notes:   register index times four gives the byte address
`ifndef SADC_REGS_VH
`define SADC_REGS_VH

`define SADC_IDX_IRQ_ENABLE   8'h0B
`define SADC_IDX_IRQ_PENDING  8'h0C
`define SADC_IDX_RESULT_HIGH  8'h17
`define SADC_IDX_CTL_RESULT   8'h18
`define SADC_IDX_CHAN_REF     8'h19

`define SADC_ADDR_IRQ_ENABLE  12'h02C
`define SADC_ADDR_IRQ_PENDING 12'h030
`define SADC_ADDR_RESULT_HIGH 12'h05C
`define SADC_ADDR_CTL_RESULT  12'h060
`define SADC_ADDR_CHAN_REF    12'h064

`define SADC_BIT_DONE         7
`define SADC_BIT_START        3
`define SADC_CHAN_RESET       5'h1F
`define SADC_REF_RESET        2'h0
`define SADC_CHAN_LAST_EXT    5'h0C
`define SADC_CHAN_BANDGAP     5'h0E
`define SADC_CHAN_QUARTER     5'h17
`define SADC_REF_RESERVED     2'h2
`define SADC_RESULT_BITS      12
// one sample cycle plus one per result bit, in converter clocks
`define SADC_CONV_STEPS       4'hD

`endif

// ===== hdl/sadc_clock_divider.v
// Purpose: converter clock enable from the system clock
// Assumes: enable pulse lasts one system clock
// Notes:   code 000 divides by 256, 111 divides by 2
`timescale 1ns/1ns
module sadc_clock_divider
(
  input  wire       clk,
  input  wire       reset,
  input  wire [2:0] divSelect,
  output reg        convTick
);

  reg  [7:0] count;
  wire [7:0] limit;

  // divide by 2^(8-code); limit is that minus one
  assign limit = (8'hFF >> divSelect);

  always @(posedge clk)
  begin
    if (reset)
    begin
      count    <= 8'h00;
      convTick <= 1'b0;
    end
    else if (count >= limit)
    begin
      count    <= 8'h00;
      convTick <= 1'b1;
    end
    else
    begin
      count    <= count + 8'h01;
      convTick <= 1'b0;
    end
  end

endmodule

// ===== hdl/sadc_control.v
// Purpose: control of a 12-bit successive-approximation converter behind APB
// Assumes: analog comparator result arrives synchronous to clk
// Notes:   one clock domain; converter steps ride on a divided enable
`timescale 1ns/1ns
`include "sadc_regs.vh"
module sadc_control
(
  input  wire        clk,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        compareHigh,
  output reg  [11:0] trialCode,
  output reg         sampleHold,
  output reg  [4:0]  muxSelect,
  output reg         muxValid,
  output reg  [1:0]  refSelect,
  output reg         bandgapHighLevel,
  output reg         convIrq
);

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg  [7:0]  irqEnable;
  reg  [7:0]  irqPending;
  reg  [2:0]  divSelect;
  reg         startBit;
  reg  [4:0]  chanSelect;
  reg  [1:0]  refField;
  reg  [11:0] result;
  reg  [11:0] sarReg;
  reg  [3:0]  step;
  reg  [3:0]  bitIndex;
  reg         busy;
  reg         doneEvent;
  wire        convTick;

  localparam ST_IDLE   = 1'b0;
  localparam ST_CONV   = 1'b1;

  wire access   = psel & penable;
  wire wrAccess = access & pwrite & pstrb[0];

  function hit;
    input [11:0] addr;
    input [11:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  function chanLegal;
    input [4:0] code;
    begin
      chanLegal = (code <= `SADC_CHAN_LAST_EXT) || (code == `SADC_CHAN_BANDGAP) ||
                  (code == `SADC_CHAN_QUARTER);
    end
  endfunction

  sadc_clock_divider u_div
  (
    .clk      (clk),
    .reset    (reset),
    .divSelect(divSelect),
    .convTick (convTick)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait state, unmapped addresses answer with pslverr

  wire mapped = hit(paddr, `SADC_ADDR_IRQ_ENABLE) | hit(paddr, `SADC_ADDR_IRQ_PENDING) |
                hit(paddr, `SADC_ADDR_RESULT_HIGH) | hit(paddr, `SADC_ADDR_CTL_RESULT) |
                hit(paddr, `SADC_ADDR_CHAN_REF);

  reg [7:0] readByte;
  always @*
  begin
    readByte = 8'h00;
    if (hit(paddr, `SADC_ADDR_IRQ_ENABLE))
      readByte = irqEnable;
    else if (hit(paddr, `SADC_ADDR_IRQ_PENDING))
      readByte = irqPending;
    else if (hit(paddr, `SADC_ADDR_RESULT_HIGH))
      readByte = result[11:4];
    else if (hit(paddr, `SADC_ADDR_CTL_RESULT))
      readByte = {result[3:0], startBit, divSelect};
    else if (hit(paddr, `SADC_ADDR_CHAN_REF))
      readByte = {refField, 1'b0, chanSelect};
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      // answer in the setup cycle so the access phase completes at once
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? {24'h000000, readByte} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers

  wire wrEnable  = wrAccess & hit(paddr, `SADC_ADDR_IRQ_ENABLE);
  wire wrPending = wrAccess & hit(paddr, `SADC_ADDR_IRQ_PENDING);
  wire wrCtl     = wrAccess & hit(paddr, `SADC_ADDR_CTL_RESULT);
  wire wrChan    = wrAccess & hit(paddr, `SADC_ADDR_CHAN_REF);
  wire startReq  = wrCtl & pwdata[`SADC_BIT_START] & ~busy;

  always @(posedge clk)
  begin
    if (reset)
    begin
      irqEnable  <= 8'h00;
      irqPending <= 8'h00;
      divSelect  <= 3'h0;
      chanSelect <= `SADC_CHAN_RESET;
      refField   <= `SADC_REF_RESET;
    end
    else
    begin
      if (wrEnable)
        irqEnable <= pwdata[7:0];
      // written zeros clear; set from hardware wins in the same cycle
      if (wrPending)
        irqPending <= irqPending & pwdata[7:0];
      if (doneEvent)
        irqPending[`SADC_BIT_DONE] <= 1'b1;
      if (wrCtl)
        divSelect <= pwdata[2:0];
      if (wrChan)
      begin
        chanSelect <= pwdata[4:0];
        refField   <= pwdata[7:6];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // successive approximation sequencer

  always @(posedge clk)
  begin
    if (reset)
    begin
      busy      <= ST_IDLE;
      startBit  <= 1'b0;
      sarReg    <= 12'h000;
      step      <= 4'h0;
      bitIndex  <= 4'h0;
      result    <= 12'h000;
      doneEvent <= 1'b0;
      sampleHold <= 1'b0;
      trialCode <= 12'h000;
    end
    else
    begin
      doneEvent <= 1'b0;
      case (busy)
        ST_IDLE:
        begin
          if (startReq)
          begin
            busy       <= ST_CONV;
            startBit   <= 1'b1;
            step       <= 4'h0;
            sampleHold <= 1'b1;
            sarReg     <= 12'h000;
          end
        end
        ST_CONV:
        begin
          if (convTick)
          begin
            step <= step + 4'h1;
            if (step == 4'h0)
            begin
              // sample phase ends; first trial is mid-scale
              sampleHold <= 1'b0;
              bitIndex   <= 4'hB;
              trialCode  <= 12'h800;
            end
            else if (step < `SADC_CONV_STEPS)
            begin
              sarReg[bitIndex] <= compareHigh;
              if (bitIndex != 4'h0)
              begin
                bitIndex  <= bitIndex - 4'h1;
                trialCode <= (sarReg | ({11'h000, compareHigh} << bitIndex)) |
                             (12'h001 << (bitIndex - 4'h1));
              end
              else
              begin
                // result updates only here, so it holds between conversions
                result    <= {sarReg[11:1], compareHigh};
                busy      <= ST_IDLE;
                startBit  <= 1'b0;
                doneEvent <= 1'b1;
              end
            end
          end
        end
        default:
          busy <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // analog routing and interrupt

  always @(posedge clk)
  begin
    if (reset)
    begin
      muxSelect        <= `SADC_CHAN_RESET;
      muxValid         <= 1'b0;
      refSelect        <= `SADC_REF_RESET;
      bandgapHighLevel <= 1'b0;
      convIrq          <= 1'b0;
    end
    else
    begin
      muxSelect        <= chanSelect;
      muxValid         <= chanLegal(chanSelect);
      // reserved reference code falls back to supply reference
      refSelect        <= (refField == `SADC_REF_RESERVED) ? 2'h0 : refField;
      bandgapHighLevel <= refField[0];
      convIrq          <= |(irqPending & irqEnable);
    end
  end

endmodule

// ===== verif/sadc_control_sva.sv
// Purpose: port checks of converter control
// Assumes: zero-wait APB answers
// Notes:   bind at foot
`timescale 1ns/1ns
module sadc_control_sva
(
  input wire        clk,
  input wire        reset,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [11:0] trialCode,
  input wire        sampleHold,
  input wire [4:0]  muxSelect,
  input wire        muxValid,
  input wire [1:0]  refSelect,
  input wire        bandgapHighLevel,
  input wire        convIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  function automatic logic legal(input logic [4:0] c);
    return c <= 5'h0C || c == 5'h0E || c == 5'h17;
  endfunction
  ////////////////////////////////////////////////////////////
  sequence wrTo(a);
    psel && penable && pready && pwrite && pstrb[0] && paddr == a;
  endsequence
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("lone error");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
  a_irq_off: assert property (wrTo(12'h02C) ##0 pwdata[7:0] == 8'h00 |-> ##2 !convIrq) else $error("irq");
  a_irq_clear: assert property (wrTo(12'h030) ##0 pwdata[7:0] == 8'h7F |-> ##2 !convIrq) else $error("clr");
  a_mux_copy: assert property (wrTo(12'h064) |-> ##2 muxSelect == $past(pwdata[4:0], 2)
    && muxValid == legal($past(pwdata[4:0], 2))) else $error("channel");
  a_ref_map: assert property (wrTo(12'h064) |-> ##2 bandgapHighLevel == $past(pwdata[6], 2)
    && refSelect == ($past(pwdata[7:6], 2) == 2'h2 ? 2'h0 : $past(pwdata[7:6], 2))) else $error("ref");
  a_hold_trial: assert property ($fell(sampleHold) |-> trialCode == 12'h800) else $error("trial");
endmodule
bind sadc_control sadc_control_sva sadc_control_sva_i (.*);

// ===== verif/sadc_analog_model.sv
// Purpose: analog side, one level per channel
// Assumes: comparator settles within a clock
// Notes:   reserved codes still give a level
`timescale 1ns/1ns
module sadc_analog_model
(
  input  wire [11:0] trialCode,
  input  wire [4:0]  muxSelect,
  output wire        compareHigh
);
  wire [11:0] level;
  // distinct level per input, so a wrong route shows
  // pins taken as set to analog mode by software
  assign level = {muxSelect, muxSelect ^ 5'h15, 2'h2};
  assign compareHigh = (level >= trialCode);
endmodule

// ===== verif/tb_sadc_control.sv
// Purpose: self-checking bench of converter control
// Assumes: zero-wait APB slave
// Notes:   reads queue their expected value
`timescale 1ns/1ns
module tb_sadc_control;
  reg          clk, reset, psel, penable, pwrite;
  reg   [11:0] paddr;
  reg   [31:0] pwdata;
  reg   [3:0]  pstrb;
  wire  [31:0] prdata;
  wire         pready, pslverr, compareHigh, sampleHold, muxValid, bandgapHighLevel, convIrq;
  wire  [11:0] trialCode;
  wire  [4:0]  muxSelect;
  wire  [1:0]  refSelect;
  logic [63:0] notes[$];
  logic [31:0] rd;
  logic [11:0] level, prevLevel;
  logic [4:0]  chan;
  logic        slvErr;
  integer      errors, num_checks, cycles, t0, div, i;
  sadc_control sadc_control_i (.*);
  sadc_analog_model sadc_analog_model_i (.trialCode(trialCode), .muxSelect(muxSelect), .compareHigh(compareHigh));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // mask zero marks a poll whose value is not judged
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
    integer n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    if (!w) notes.push_back({m, d & m});
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors = errors + 1;
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (psel && penable && pready && !pwrite && notes.size() > 0)
    begin
      check(prdata & notes[0][63:32], notes[0][31:0]);
      void'(notes.pop_front());
    end
    if (cycles == 30000)
    begin
      errors = errors + 1;
      print_verdict;
    end
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    errors = 0; num_checks = 0; cycles = 0; reset = 1'b1; prevLevel = 12'h000;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hF;
    void'($urandom(40));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    apb(0, 12'h02C, 0, 32'hFF);
    apb(0, 12'h030, 0, 32'hFF);
    apb(0, 12'h064, 32'h1F, 32'hFF);
    apb(0, 12'h010, 0, 32'hFFFFFFFF);
    check(slvErr, 1);
    pstrb <= 4'h0;
    apb(1, 12'h02C, 32'hFF, 0);
    pstrb <= 4'hF;
    apb(0, 12'h02C, 0, 32'hFF);
    for (i = 0; i < 32; i++)
    begin
      apb(1, 12'h064, i | ((i % 4) << 6), 0);
      apb(0, 12'h064, i | ((i % 4) << 6), (i % 4 == 2) ? 32'h3F : 32'hFF);
    end
    repeat (4000) @(posedge clk);
    // fast divider codes only read back: at 20 MHz they exceed the 1 MHz limit
    for (div = 4; div < 8; div++)
    begin
      apb(1, 12'h060, div, 0);
      apb(0, 12'h060, {prevLevel[3:0], 1'b0, div[2:0]}, 32'hFF);
    end
    for (div = 0; div < 4; div++)
    begin
      chan = $urandom;
      level = {chan, chan ^ 5'h15, 2'h2};
      apb(1, 12'h02C, div[0] ? 32'h80 : 32'h00, 0);
      apb(1, 12'h064, {24'h0, 3'h6, chan}, 0);
      apb(1, 12'h060, 32'h8 | div, 0);
      t0 = cycles;
      apb(0, 12'h05C, prevLevel[11:4], 32'hFF);
      rd = 32'h8;
      while (rd[3] && cycles - t0 < 4000) apb(0, 12'h060, 0, 0);
      check((cycles - t0 >= 12 * (1 << (8 - div)) - 2) && (cycles - t0 <= 13 * (1 << (8 - div)) + 6), 1);
      apb(0, 12'h05C, level[11:4], 32'hFF);
      apb(0, 12'h060, {level[3:0], 1'b0, div[2:0]}, 32'hFF);
      check(convIrq, div[0]);
      apb(0, 12'h030, 32'h80, 32'hFF);
      apb(1, 12'h030, 32'h7F, 0);
      apb(0, 12'h030, 0, 32'hFF);
      check(convIrq, 0);
      prevLevel = level;
    end
    print_verdict;
  end
endmodule
